// File: core/bdper_pkg.sv
// Package: constants and types of the data parity error report block
package bdper_pkg;

	// Register byte offsets
	localparam logic [7:0] BDPER_CTRL_OFS   = 8'h00;
	localparam logic [7:0] BDPER_STATUS_OFS = 8'h04;
	localparam logic [7:0] BDPER_MASK_OFS   = 8'h08;
	localparam logic [7:0] BDPER_LOG_OFS    = 8'h0c;

	// Control fields
	localparam int BDPER_CTRL_W      = 2;
	localparam int BDPER_CTRL_PRI_EN = 0;
	localparam int BDPER_CTRL_SEC_EN = 1;
	localparam logic [1:0] BDPER_CTRL_RST = 2'h0;

	// Status and mask fields
	localparam int BDPER_NSTAT       = 4;
	localparam int BDPER_ST_SEC_DET  = 0;
	localparam int BDPER_ST_PRI_MDPE = 1;
	localparam int BDPER_ST_SEC_MDPE = 2;
	localparam int BDPER_ST_PERR     = 3;
	localparam logic [3:0] BDPER_STATUS_RST = 4'h0;
	localparam logic [3:0] BDPER_MASK_RST   = 4'h0;

	// Cycles from failing data transfer to error pin low
	localparam int BDPER_PERR_DLY = 2;

	// AHB-Lite transfer type bit that marks an active transfer
	localparam int BDPER_HTRANS_ACT = 1;

	// Kind of transaction being reported
	typedef enum logic [1:0] {
		BDPER_READ    = 2'b00,
		BDPER_POSTED  = 2'b01,
		BDPER_DELAYED = 2'b10
	} bdper_kind_t;

	// One data transfer report from the bridge datapath
	typedef struct packed {
		logic        valid;
		bdper_kind_t kind;
		logic        upstream;
		logic        on_sec;
		logic        det;
		logic        cmpl;
	} bdper_xfer_t;

	// Record of the last transfer that set a status bit
	typedef struct packed {
		logic        seen;
		bdper_kind_t kind;
		logic        upstream;
		logic        on_sec;
	} bdper_log_t;

	// AHB-Lite slave request and response
	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} bdper_ahb_req_t;

	typedef struct packed {
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} bdper_ahb_rsp_t;

endpackage : bdper_pkg

// File: core/bdper_perr_drv.sv
// Module: delayed driver of the primary parity error pin
`timescale 1ns/100ps
module bdper_perr_drv (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic fire,
	output logic      pin_out,
	output logic      pin_oe_n
);
	import bdper_pkg::*;

	typedef struct packed {
		logic [BDPER_PERR_DLY-1:0] pipe;
		logic                      tail;
	} bdper_drv_st_t;

	bdper_drv_st_t st;
	bdper_drv_st_t next_st;

	// Shift each report toward the pin; the last low beat of a run is followed by a high one
	always_comb begin
		next_st      = st;
		next_st.pipe = {st.pipe[BDPER_PERR_DLY-2:0], fire};
		next_st.tail = st.pipe[BDPER_PERR_DLY-1];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Pin low on the delayed beat, driven high one beat more, then released
	always_comb begin
		pin_out  = ~st.pipe[BDPER_PERR_DLY-1];
		pin_oe_n = ~(st.pipe[BDPER_PERR_DLY-1] | st.tail);
	end

	default clocking dcb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_low_two;
		fire |-> ##2 (!pin_out && !pin_oe_n);
	endproperty
	a_low_two: assert property (p_low_two)
		else $error("error pin not low two cycles after report");

	property p_low_cause;
		$fell(pin_out) |-> $past(fire, 2);
	endproperty
	a_low_cause: assert property (p_low_cause)
		else $error("error pin low without report two cycles before");

	property p_high_tail;
		(!pin_out ##1 pin_out) |-> !pin_oe_n;
	endproperty
	a_high_tail: assert property (p_high_tail)
		else $error("error pin released without high beat");

endmodule : bdper_perr_drv

// File: core/bdper_top.sv
// Module: data parity error status, pin reporting and AHB-Lite registers
//
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module bdper_top (
	input  wire logic                      hclk,
	input  wire logic                      hresetn,
	input  wire bdper_pkg::bdper_ahb_req_t ahb_req,
	output bdper_pkg::bdper_ahb_rsp_t      ahb_rsp,
	input  wire bdper_pkg::bdper_xfer_t    xfer,
	input  wire logic                      primary_parity_err_n_in,
	input  wire logic                      secondary_parity_err_n_in,
	output logic                           primary_parity_err_n_out,
	output logic                           primary_parity_err_n_oe_n,
	output logic                           irq
);
	import bdper_pkg::*;

	// Whole register state of the block
	typedef struct packed {
		logic [BDPER_CTRL_W-1:0] ctrl;
		logic [BDPER_NSTAT-1:0]  status;
		logic [BDPER_NSTAT-1:0]  mask;
		bdper_log_t              log;
		logic                    irq;
		logic                    wr_pend;
		logic [7:0]              waddr;
		logic [31:0]             rdata;
	} bdper_state_t;

	bdper_state_t st;
	bdper_state_t next_st;

	logic                   pri_en;
	logic                   sec_en;
	logic                   is_rd;
	logic                   is_wr;
	logic                   is_dly;
	logic                   on_pri;
	logic                   on_sec;
	logic                   ppin_low;
	logic                   spin_low;
	logic                   fire_perr;
	logic                   perr_own;
	logic                   perr_cmpl;
	logic                   take;
	logic [BDPER_NSTAT-1:0] set_v;
	logic [BDPER_NSTAT-1:0] clr_v;
	logic [31:0]            rd_word;

	// Qualify the transfer report and the enables
	always_comb begin
		pri_en   = st.ctrl[BDPER_CTRL_PRI_EN];
		sec_en   = st.ctrl[BDPER_CTRL_SEC_EN];
		is_rd    = xfer.kind == BDPER_READ;
		is_dly   = xfer.kind == BDPER_DELAYED;
		is_wr    = (xfer.kind == BDPER_POSTED) | is_dly;
		on_pri   = xfer.valid & ~xfer.on_sec;
		on_sec   = xfer.valid & xfer.on_sec;
		ppin_low = ~primary_parity_err_n_in;
		spin_low = ~secondary_parity_err_n_in;
	end

	// Decide which status bits this transfer sets
	always_comb begin
		set_v = '0;
		// Own secondary error on read down or write up, enables ignored
		set_v[BDPER_ST_SEC_DET] = on_sec & xfer.det
			& ((is_rd & ~xfer.upstream) | (is_wr & xfer.upstream));
		// Bridge is primary master only for upstream traffic
		set_v[BDPER_ST_PRI_MDPE] = on_pri & xfer.upstream
			& pri_en
			& (is_rd | is_wr)
			& (xfer.det | ppin_low);
		// Bridge is secondary master only for downstream traffic
		set_v[BDPER_ST_SEC_MDPE] = on_sec & ~xfer.upstream
			& sec_en
			& (is_rd | is_wr)
			& (xfer.det | spin_low);
		set_v[BDPER_ST_PERR] = fire_perr;
	end

	// Decide whether the primary error pin is to be asserted
	always_comb begin
		// Write target or read initiator on the primary bus
		perr_own = on_pri & xfer.det
			& ((is_rd & xfer.upstream) | (is_wr & ~xfer.upstream));
		// Target reported error while completing a downstream delayed write
		perr_cmpl = on_sec & is_dly & ~xfer.upstream & xfer.cmpl
			& spin_low & sec_en;
		fire_perr = pri_en & (perr_own | perr_cmpl);
	end

	// Bus handshake and write-one-to-clear mask
	always_comb begin
		take  = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[BDPER_HTRANS_ACT];
		clr_v = '0;
		if (st.wr_pend && st.waddr == BDPER_STATUS_OFS) begin
			clr_v = ahb_req.hwdata[BDPER_NSTAT-1:0];
		end
	end

	// Next state of all registers
	always_comb begin
		next_st = st;
		rd_word = '0;
		// Data phase of a write lands in the register
		if (st.wr_pend) begin
			case (st.waddr)
				BDPER_CTRL_OFS: begin
					next_st.ctrl = ahb_req.hwdata[BDPER_CTRL_W-1:0];
				end
				BDPER_MASK_OFS: begin
					next_st.mask = ahb_req.hwdata[BDPER_NSTAT-1:0];
				end
				BDPER_LOG_OFS: begin
					next_st.log = '0;
				end
				default: begin
					next_st.ctrl = st.ctrl;
				end
			endcase
		end
		// Sticky status: a new event wins over a clear in the same cycle
		for (int i = 0; i < BDPER_NSTAT; i++) begin
			next_st.status[i] = set_v[i] | (st.status[i] & ~clr_v[i]);
		end
		// Record the transfer behind the latest event
		if (|set_v) begin
			next_st.log.seen     = 1'b1;
			next_st.log.kind     = xfer.kind;
			next_st.log.upstream = xfer.upstream;
			next_st.log.on_sec   = xfer.on_sec;
		end
		next_st.irq = |(next_st.status & next_st.mask);
		// Latch the address phase
		next_st.wr_pend = take & ahb_req.hwrite;
		next_st.waddr   = ahb_req.haddr[7:0];
		// Read mux sees the values after any write in its data phase
		case (ahb_req.haddr[7:0])
			BDPER_CTRL_OFS: begin
				rd_word[BDPER_CTRL_W-1:0] = next_st.ctrl;
			end
			BDPER_STATUS_OFS: begin
				rd_word[BDPER_NSTAT-1:0] = next_st.status;
			end
			BDPER_MASK_OFS: begin
				rd_word[BDPER_NSTAT-1:0] = next_st.mask;
			end
			BDPER_LOG_OFS: begin
				rd_word[$bits(bdper_log_t)-1:0] = next_st.log;
			end
			default: begin
				rd_word = '0;
			end
		endcase
		// Read data is taken only from the register fields, so no loop through rdata
		next_st.rdata = '0;
		if (take && !ahb_req.hwrite) begin
			next_st.rdata = rd_word;
		end
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st        <= '0;
			st.ctrl   <= BDPER_CTRL_RST;
			st.status <= BDPER_STATUS_RST;
			st.mask   <= BDPER_MASK_RST;
		end else begin
			st <= next_st;
		end
	end

	// Pin driver with the fixed report delay
	bdper_perr_drv u_perr_drv (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.fire     (fire_perr),
		.pin_out  (primary_parity_err_n_out),
		.pin_oe_n (primary_parity_err_n_oe_n)
	);

	// Zero wait state slave, always OKAY
	always_comb begin
		ahb_rsp.hrdata    = st.rdata;
		ahb_rsp.hreadyout = 1'b1;
		ahb_rsp.hresp     = 1'b0;
		irq               = st.irq;
	end

	default clocking dcb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_pri_mdpe_set;
		(on_pri && xfer.upstream && pri_en && (is_rd || is_wr) && (xfer.det || ppin_low))
			|=> st.status[BDPER_ST_PRI_MDPE];
	endproperty
	a_pri_mdpe_set: assert property (p_pri_mdpe_set)
		else $error("primary master bit not set");

	property p_pri_mdpe_cause;
		$rose(st.status[BDPER_ST_PRI_MDPE])
			|-> $past(on_pri && xfer.upstream && pri_en);
	endproperty
	a_pri_mdpe_cause: assert property (p_pri_mdpe_cause)
		else $error("primary master bit set without cause");

	property p_sec_mdpe_set;
		(on_sec && !xfer.upstream && sec_en && (is_rd || is_wr) && (xfer.det || spin_low))
			|=> st.status[BDPER_ST_SEC_MDPE];
	endproperty
	a_sec_mdpe_set: assert property (p_sec_mdpe_set)
		else $error("secondary master bit not set");

	property p_sec_mdpe_cause;
		$rose(st.status[BDPER_ST_SEC_MDPE])
			|-> $past(on_sec && !xfer.upstream && sec_en);
	endproperty
	a_sec_mdpe_cause: assert property (p_sec_mdpe_cause)
		else $error("secondary master bit set without cause");

	property p_sec_det;
		(on_sec && xfer.det && ((is_rd && !xfer.upstream) || (is_wr && xfer.upstream)))
			|=> st.status[BDPER_ST_SEC_DET];
	endproperty
	a_sec_det: assert property (p_sec_det)
		else $error("secondary detected bit not set");

	property p_sticky;
		(($past(st.status) & ~st.status)
			& ~$past(st.wr_pend && st.waddr == BDPER_STATUS_OFS
			? ahb_req.hwdata[BDPER_NSTAT-1:0] : 4'h0)) == 4'h0;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("status bit dropped without write of one");

	property p_perr_own;
		(on_pri && xfer.det && pri_en && is_rd && xfer.upstream)
			|-> ##2 (!primary_parity_err_n_out && !primary_parity_err_n_oe_n);
	endproperty
	a_perr_own: assert property (p_perr_own)
		else $error("primary error pin missed own read error");

	property p_perr_cmpl;
		(on_sec && is_dly && !xfer.upstream && xfer.cmpl && spin_low
			&& pri_en && sec_en) |-> ##2 !primary_parity_err_n_out;
	endproperty
	a_perr_cmpl: assert property (p_perr_cmpl)
		else $error("primary error pin missed completion error");

	property p_perr_cause;
		$fell(primary_parity_err_n_out)
			|-> $past(pri_en, 2) && $past(on_pri || on_sec, 2);
	endproperty
	a_perr_cause: assert property (p_perr_cause)
		else $error("primary error pin low without enabled cause");

	property p_irq;
		irq == (|(st.status & st.mask));
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt does not follow masked status");

endmodule : bdper_top

// File: testbench/bdper_pci_agents.sv
// Model of the bus agents that share the two parity error lines
`timescale 1ns/100ps
module bdper_pci_agents (
	input  wire logic pri_low,
	input  wire logic sec_low,
	input  wire logic drv_out,
	input  wire logic drv_oe_n,
	output logic      pri_wire,
	output logic      sec_wire
);
	// Both lines have pull-ups, so a released line reads high
	assign pri_wire = !(pri_low || (!drv_oe_n && !drv_out));
	assign sec_wire = !sec_low;
endmodule : bdper_pci_agents

// File: testbench/bdper_top_tb.sv
// Self-checking testbench of the data parity error report block
`timescale 1ns/100ps
module bdper_top_tb;
	import bdper_pkg::*;
	logic           hclk = 1'b0;
	logic           hresetn = 1'b0;
	bdper_ahb_req_t m = '0;
	bdper_ahb_req_t bus_req;
	bdper_ahb_rsp_t rsp;
	bdper_xfer_t    xfer = '0;
	logic           pri_low = 1'b0;
	logic           sec_low = 1'b0;
	logic           pri_wire, sec_wire, pin_out, pin_oe_n, irq;
	logic [31:0]    rd, seed = 32'h1f4d;
	int             fails = 0, num_checks = 0;
	event           hang;

	// Clock of 5 ns period
	always #2.5 hclk = ~hclk;
	// The one slave's ready is the bus ready
	always_comb begin
		bus_req = m;
		bus_req.hready = rsp.hreadyout;
	end

	bdper_top bdper_top_inst (
		.hclk                      (hclk),
		.hresetn                   (hresetn),
		.ahb_req                   (bus_req),
		.ahb_rsp                   (rsp),
		.xfer                      (xfer),
		.primary_parity_err_n_in   (pri_wire),
		.secondary_parity_err_n_in (sec_wire),
		.primary_parity_err_n_out  (pin_out),
		.primary_parity_err_n_oe_n (pin_oe_n),
		.irq                       (irq)
	);

	bdper_pci_agents bdper_pci_agents_inst (
		.pri_low  (pri_low),
		.sec_low  (sec_low),
		.drv_out  (pin_out),
		.drv_oe_n (pin_oe_n),
		.pri_wire (pri_wire),
		.sec_wire (sec_wire)
	);

	// Next value of the random source
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Expected status; v holds en[1:0] kind up sec det plo slo cmpl
	function automatic logic [3:0] exp_stat(input logic [9:0] v);
		logic       rd_k, wr_k;
		logic [3:0] s;
		rd_k = v[7:6] == 2'b00;
		wr_k = v[7:6] == 2'b01 || v[7:6] == 2'b10;
		s[0] = v[4] & v[3] & ((~v[5] & rd_k) | (v[5] & wr_k));
		s[1] = (rd_k | wr_k) & v[5] & ~v[4] & v[8] & (v[3] | v[2]);
		s[2] = (rd_k | wr_k) & ~v[5] & v[4] & v[9] & (v[3] | v[1]);
		s[3] = v[8] & ((~v[4] & v[3] & ((v[5] & rd_k) | (~v[5] & wr_k)))
			| (v[7:6] == 2'b10 & ~v[5] & v[4] & v[0] & v[1] & v[9]));
		return s;
	endfunction : exp_stat

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Bounded wait for hready at a rising edge
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (rsp.hreadyout !== 1'b1 && n < 40);
		if (n >= 40) begin
			fails++;
			->hang;
		end
	endtask : wait_ready

	// One single word transfer; read data lands in rd
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		m.hsel <= 1'b1;
		m.haddr <= {24'h0, a};
		m.htrans <= 2'h2;
		m.hwrite <= w;
		m.hsize <= 3'h2;
		wait_ready();
		// Read data stands only in a data phase
		chk(rsp.hrdata, 32'h0);
		m.hsel <= 1'b0;
		m.htrans <= 2'h0;
		m.hwdata <= wd;
		wait_ready();
		rd = rsp.hrdata;
		chk(32'(rsp.hresp), 32'h0);
	endtask : bus

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdchk

	// One report cycle with the far-side pin levels
	task automatic report(input logic [9:0] v);
		xfer <= bdper_xfer_t'({1'b1, v[7:3], v[0]});
		pri_low <= v[2];
		sec_low <= v[1];
		@(posedge hclk);
		xfer <= '0;
		pri_low <= 1'b0;
		sec_low <= 1'b0;
	endtask : report

	// Set enables and mask, report, then watch pin, status, log and clearing
	task automatic run_case(input logic [9:0] v, input logic [3:0] mk);
		logic [3:0] e;
		e = exp_stat(v);
		bus(1'b1, BDPER_CTRL_OFS, {30'h0, v[9:8]});
		bus(1'b1, BDPER_MASK_OFS, {28'h0, mk});
		report(v);
		#1 chk(32'(pin_oe_n), 32'h1);
		@(posedge hclk);
		#1 chk(32'({pin_out, pin_oe_n}), e[3] ? 32'h0 : 32'h3);
		@(posedge hclk);
		#1 chk(32'({pin_out, pin_oe_n, irq}), {29'h0, 1'b1, ~e[3], |(e & mk)});
		@(posedge hclk);
		#1 chk(32'(pin_oe_n), 32'h1);
		bus(1'b1, BDPER_STATUS_OFS, 32'h0);
		rdchk(BDPER_STATUS_OFS, {28'h0, e});
		rdchk(BDPER_LOG_OFS, (e != 4'h0) ? {27'h0, 1'b1, v[7:4]} : 32'h0);
		bus(1'b1, BDPER_STATUS_OFS, 32'hf);
		bus(1'b1, BDPER_LOG_OFS, 32'h0);
		rdchk(BDPER_STATUS_OFS, 32'h0);
		chk(32'(irq), 32'h0);
	endtask : run_case

	// Print the counts and the verdict, then stop
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish

	// Main sequence
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		#1 chk(32'({pin_out, pin_oe_n, irq}), 32'h6);
		for (int i = 0; i < 5; i++)
			rdchk(8'(i * 4), 32'h0);
		// Every combination, then random ones
		for (int i = 0; i < 1024; i++) begin
			seed = lfsr(seed);
			run_case(10'(i), seed[3:0]);
		end
		for (int i = 0; i < 200; i++) begin
			seed = lfsr(seed);
			run_case(seed[13:4], seed[3:0]);
		end
		// Back-to-back upstream read reports give two low cycles
		bus(1'b1, BDPER_CTRL_OFS, 32'h1);
		xfer <= bdper_xfer_t'(7'b1001010);
		@(posedge hclk);
		@(posedge hclk);
		xfer <= '0;
		for (int i = 0; i < 4; i++) begin
			#1 chk(32'({pin_out, pin_oe_n}), (i < 2) ? 32'h0 : 32'(i));
			@(posedge hclk);
		end
		rdchk(BDPER_STATUS_OFS, 32'ha);
		// Reset in mid-run clears set status
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		#1 chk(32'({pin_out, pin_oe_n, irq}), 32'h6);
		rdchk(BDPER_STATUS_OFS, 32'h0);
		rdchk(BDPER_CTRL_OFS, 32'h0);
		tally_and_finish();
	end

	// A wait that ran out ends the run
	initial begin
		@hang;
		tally_and_finish();
	end
endmodule : bdper_top_tb
